// ===== hw/fsp_defs.vh
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// register byte offsets on the bus
`define FSP_OFF_PROT        8'h00
`define FSP_OFF_STAT        8'h04
`define FSP_OFF_ADDR_W      8

// protection setting fields
`define FSP_OPEN_BIT        7
`define FSP_SPARE_BIT       6
`define FSP_HDIS_BIT        5
`define FSP_HS_HI           4
`define FSP_HS_LO           3
`define FSP_LDIS_BIT        2
`define FSP_LS_HI           1
`define FSP_LS_LO           0
`define FSP_PROT_RST        8'h00

// status register fields
`define FSP_STAT_VIOL_BIT   0
`define FSP_STAT_LOAD_BIT   1
`define FSP_STAT_SCEN_LO    2
`define FSP_STAT_SCEN_HI    4

// protection byte location in the array
`define FSP_LOAD_ADDR       16'hFF0D

// high range start per size code, all end at top of map
`define FSP_HI_START_0      16'hF800
`define FSP_HI_START_1      16'hF000
`define FSP_HI_START_2      16'hE000
`define FSP_HI_START_3      16'hC000
`define FSP_HI_END          16'hFFFF

// low range end per size code, all start at the same base
`define FSP_LO_START        16'h4000
`define FSP_LO_END_0        16'h43FF
`define FSP_LO_END_1        16'h47FF
`define FSP_LO_END_2        16'h4FFF
`define FSP_LO_END_3        16'h5FFF

// allowed target scenarios per source, bit n = target n
`define FSP_ALLOW_0         8'h0F
`define FSP_ALLOW_1         8'h0A
`define FSP_ALLOW_2         8'h0C
`define FSP_ALLOW_3         8'h08
`define FSP_ALLOW_4         8'h18
`define FSP_ALLOW_5         8'h3A
`define FSP_ALLOW_6         8'h5A
`define FSP_ALLOW_7         8'hFF

`define FSP_RESP_OKAY       2'b00
`define FSP_RESP_SLVERR     2'b10

`endif

// ===== hw/fsp_range_dec.v
`include "fsp_defs.vh"
`default_nettype none

module fsp_range_dec (
   input  wire [15:0] addr,
   input  wire [7:0]  setting,
   output wire        is_protected
);

   wire [1:0] hs = setting[`FSP_HS_HI:`FSP_HS_LO];
   wire [1:0] ls = setting[`FSP_LS_HI:`FSP_LS_LO];
   reg  [15:0] hi_start;
   reg  [15:0] lo_end;

   always @* begin
      case (hs)
         2'b00:   hi_start = `FSP_HI_START_0;
         2'b01:   hi_start = `FSP_HI_START_1;
         2'b10:   hi_start = `FSP_HI_START_2;
         default: hi_start = `FSP_HI_START_3;
      endcase
      case (ls)
         2'b00:   lo_end = `FSP_LO_END_0;
         2'b01:   lo_end = `FSP_LO_END_1;
         2'b10:   lo_end = `FSP_LO_END_2;
         default: lo_end = `FSP_LO_END_3;
      endcase
   end

   // a disable bit of 1 removes its range entirely
   wire in_hi = !setting[`FSP_HDIS_BIT] && addr >= hi_start
                && addr <= `FSP_HI_END;
   wire in_lo = !setting[`FSP_LDIS_BIT] && addr >= `FSP_LO_START
                && addr <= lo_end;
   wire in_any = in_hi | in_lo;

   // open polarity: ranges protected; closed: ranges are the only holes
   assign is_protected = setting[`FSP_OPEN_BIT] ? in_any
                                                : !in_any;

endmodule // fsp_range_dec
`default_nettype wire

// ===== hw/fsp_loader.v
`include "fsp_defs.vh"
`default_nettype none

module fsp_loader (
   input  wire        ref_clk,
   input  wire        resetn,
   input  wire [7:0]  flash_rd_data,
   input  wire        flash_rd_valid,
   output reg         flash_rd_req,
   output reg  [15:0] flash_rd_addr,
   output reg         ld_done,
   output reg  [7:0]  ld_data
);

   localparam ST_REQ  = 1'b0;
   localparam ST_DONE = 1'b1;

   reg state_reg;

   // fetch the stored protection byte once after reset
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg     <= ST_REQ;
         flash_rd_req  <= 1'b0;
         flash_rd_addr <= 16'h0000;
         ld_done       <= 1'b0;
         ld_data       <= 8'h00;
      end else begin
         case (state_reg)
            ST_REQ: begin
               flash_rd_addr <= `FSP_LOAD_ADDR;
               flash_rd_req  <= !flash_rd_valid;
               if (flash_rd_valid && flash_rd_req) begin
                  ld_data   <= flash_rd_data;
                  ld_done   <= 1'b1;
                  state_reg <= ST_DONE;
               end
            end
            ST_DONE: begin
               flash_rd_req <= 1'b0;
            end
            default: state_reg <= ST_REQ;
         endcase
      end
   end

endmodule // fsp_loader
`default_nettype wire

// ===== hw/fsp_top.v
`include "fsp_defs.vh"
`default_nettype none

module fsp_top (
   input  wire        ref_clk,
   input  wire        resetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [7:0]  flash_rd_data,
   input  wire        flash_rd_valid,
   output wire        flash_rd_req,
   output wire [15:0] flash_rd_addr,
   input  wire        cmd_valid,
   input  wire        cmd_mass,
   input  wire [15:0] cmd_addr,
   output reg         cmd_accept,
   output reg         cmd_refuse,
   output reg         protect_violation_flag,
   output reg  [7:0]  prot_setting
);

   function [2:0] scen_of;
      input [7:0] s;
      begin
         scen_of = {s[`FSP_OPEN_BIT], s[`FSP_HDIS_BIT],
                    s[`FSP_LDIS_BIT]};
      end
   endfunction

   function allowed;
      input [2:0] from;
      input [2:0] to;
      reg   [7:0] mask;
      begin
         mask = 8'h00;
         case (from)
            3'd0:    mask = `FSP_ALLOW_0;
            3'd1:    mask = `FSP_ALLOW_1;
            3'd2:    mask = `FSP_ALLOW_2;
            3'd3:    mask = `FSP_ALLOW_3;
            3'd4:    mask = `FSP_ALLOW_4;
            3'd5:    mask = `FSP_ALLOW_5;
            3'd6:    mask = `FSP_ALLOW_6;
            default: mask = `FSP_ALLOW_7;
         endcase
         allowed = mask[to];
      end
   endfunction

   // ---------------- reset-time load ----------------
   // commands are refused and setting writes dropped until this load has landed
   wire       ld_done;
   wire [7:0] ld_data;
   reg        loaded_reg;

   fsp_loader u_loader (
      .ref_clk        (ref_clk),
      .resetn         (resetn),
      .flash_rd_data  (flash_rd_data),
      .flash_rd_valid (flash_rd_valid),
      .flash_rd_req   (flash_rd_req),
      .flash_rd_addr  (flash_rd_addr),
      .ld_done        (ld_done),
      .ld_data        (ld_data)
   );

   // ---------------- address decode ----------------
   // decode runs on the enforced setting, never on a pending write
   wire addr_prot;

   fsp_range_dec u_dec (
      .addr         (cmd_addr),
      .setting      (prot_setting),
      .is_protected (addr_prot)
   );

   // ---------------- bus write side ----------------
   reg        aw_got_reg;
   reg        aw_got_next;
   reg [7:0]  aw_addr_reg;
   reg [7:0]  aw_addr_next;
   reg        w_got_reg;
   reg        w_got_next;
   reg [31:0] w_data_reg;
   reg [31:0] w_data_next;
   reg [3:0]  w_strb_reg;
   reg [3:0]  w_strb_next;
   reg        bvalid_next;
   reg        do_write;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;

   always @* begin
      aw_got_next  = aw_got_reg | aw_take;
      aw_addr_next = aw_take ? s_axi_awaddr : aw_addr_reg;
      w_got_next   = w_got_reg | w_take;
      w_data_next  = w_take ? s_axi_wdata : w_data_reg;
      w_strb_next  = w_take ? s_axi_wstrb : w_strb_reg;
      bvalid_next  = s_axi_bvalid && !s_axi_bready;
      do_write     = 1'b0;
      // address and data may arrive in either order
      if (aw_got_next && w_got_next && !s_axi_bvalid) begin
         do_write    = 1'b1;
         aw_got_next = 1'b0;
         w_got_next  = 1'b0;
         bvalid_next = 1'b1;
      end
   end

   wire wr_prot = do_write && aw_addr_next == `FSP_OFF_PROT
                  && w_strb_next[0];
   wire wr_stat = do_write && aw_addr_next == `FSP_OFF_STAT
                  && w_strb_next[0];
   wire wr_map  = aw_addr_next == `FSP_OFF_PROT
                  || aw_addr_next == `FSP_OFF_STAT;

   // candidate setting: locked fields keep their old value
   wire [7:0] wd = w_data_next[7:0];
   reg  [7:0] cand;

   always @* begin
      // spare flag and size fields start from the enforced value
      cand                = prot_setting;
      cand[`FSP_OPEN_BIT] = wd[`FSP_OPEN_BIT];
      cand[`FSP_HDIS_BIT] = wd[`FSP_HDIS_BIT];
      cand[`FSP_LDIS_BIT] = wd[`FSP_LDIS_BIT];
      // size unlock follows the old disable bit, not the written one
      if (prot_setting[`FSP_HDIS_BIT]) begin
         cand[`FSP_HS_HI:`FSP_HS_LO] = wd[`FSP_HS_HI:`FSP_HS_LO];
      end
      if (prot_setting[`FSP_LDIS_BIT]) begin
         cand[`FSP_LS_HI:`FSP_LS_LO] = wd[`FSP_LS_HI:`FSP_LS_LO];
      end
   end
   // the table forbids every 0->1 of the open bit as well
   wire cand_ok = loaded_reg
                  && allowed(scen_of(prot_setting), scen_of(cand));

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         aw_got_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         w_got_reg     <= 1'b0;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `FSP_RESP_OKAY;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         aw_got_reg    <= aw_got_next;
         aw_addr_reg   <= aw_addr_next;
         w_got_reg     <= w_got_next;
         w_data_reg    <= w_data_next;
         w_strb_reg    <= w_strb_next;
         s_axi_bvalid  <= bvalid_next;
         // no new address or data while a response is pending
         s_axi_awready <= !aw_got_next && !bvalid_next;
         s_axi_wready  <= !w_got_next && !bvalid_next;
         // unmapped offsets answer with an error, nothing is stored
         if (do_write) begin
            s_axi_bresp <= wr_map ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
         end
      end
   end

   // ---------------- protection setting ----------------
   // the stored byte wins over a bus write in the same cycle
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prot_setting <= `FSP_PROT_RST;
         loaded_reg   <= 1'b0;
      end else if (ld_done && !loaded_reg) begin
         prot_setting <= ld_data;
         loaded_reg   <= 1'b1;
      end else if (wr_prot && cand_ok) begin
         prot_setting <= cand;
      end
   end

   // ---------------- command check ----------------
   wire full_open = prot_setting[`FSP_OPEN_BIT]
                    && prot_setting[`FSP_HDIS_BIT]
                    && prot_setting[`FSP_LDIS_BIT];
   wire cmd_bad   = cmd_mass ? !full_open : addr_prot;
   // nothing launches before the setting is known or while flag stands
   wire cmd_block = !loaded_reg || protect_violation_flag;
   wire viol_set  = cmd_valid && loaded_reg && cmd_bad;
   wire viol_clr  = wr_stat && wd[`FSP_STAT_VIOL_BIT];
   reg  accept_next;
   reg  refuse_next;
   reg  viol_next;

   always @* begin
      accept_next = 1'b0;
      refuse_next = 1'b0;
      viol_next   = protect_violation_flag;
      if (cmd_valid) begin
         if (cmd_block || cmd_bad) begin
            refuse_next = 1'b1;
         end else begin
            accept_next = 1'b1;
         end
      end
      // set beats a simultaneous clear
      if (viol_set) begin
         viol_next = 1'b1;
      end else if (viol_clr) begin
         viol_next = 1'b0;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cmd_accept             <= 1'b0;
         cmd_refuse             <= 1'b0;
         protect_violation_flag <= 1'b0;
      end else begin
         cmd_accept             <= accept_next;
         cmd_refuse             <= refuse_next;
         protect_violation_flag <= viol_next;
      end
   end

   // ---------------- bus read side ----------------
   wire ar_take = s_axi_arvalid && s_axi_arready;
   reg [31:0] rd_word;
   reg        rd_hit;

   always @* begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         `FSP_OFF_PROT: rd_word[7:0] = prot_setting;
         // status: flag, loaded and scenario number
         `FSP_OFF_STAT: begin
            rd_word[`FSP_STAT_VIOL_BIT] = protect_violation_flag;
            rd_word[`FSP_STAT_LOAD_BIT] = loaded_reg;
            rd_word[`FSP_STAT_SCEN_HI:`FSP_STAT_SCEN_LO] =
               scen_of(prot_setting);
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // one read at a time: arready waits for the response to go
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `FSP_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_hit ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule // fsp_top
`default_nettype wire

// ===== dv/fsp_monitor.sv
`default_nettype none
module fsp_monitor (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic        cmd_valid,
   input wire logic        cmd_mass,
   input wire logic [15:0] cmd_addr,
   input wire logic        cmd_accept,
   input wire logic        cmd_refuse,
   input wire logic        protect_violation_flag,
   input wire logic [7:0]  prot_setting,
   input wire logic        flash_rd_req
);
   timeunit 1ns;
   timeprecision 1ns;
   // bit (from*8 + to) set when the move is allowed
   localparam logic [63:0] ALLOW = 64'hFF5A_3A18_080C_0A0F;
   wire logic [2:0]  scen = {prot_setting[7], prot_setting[5],
                             prot_setting[2]};
   // 2 KB doubling per size code, always ending at the top
   wire logic [15:0] hi_start = 16'hFFFF << (5'd11 + prot_setting[4:3]);

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   AST_ONE_ANSWER: assert property (cmd_valid |=> cmd_accept != cmd_refuse)
      else $error("command not answered by one pulse");
   AST_NO_ANSWER: assert property (!cmd_valid |=> !cmd_accept && !cmd_refuse)
      else $error("answer pulse without command");
   AST_MASS_GATE: assert property (cmd_valid && cmd_mass &&
      !(prot_setting[7] && prot_setting[5] && prot_setting[2])
      |=> cmd_refuse && protect_violation_flag)
      else $error("mass erase not refused");
   AST_FULL_PROT: assert property (cmd_valid && scen == 3'b011
      |=> cmd_refuse)
      else $error("command passed with whole array protected");
   AST_HIGH_PROT: assert property (cmd_valid && scen[2:1] == 2'b10
      && cmd_addr >= hi_start |=> cmd_refuse && !cmd_accept)
      else $error("protected top range not refused");
   AST_FLAG_BLOCKS: assert property (protect_violation_flag &&
      cmd_valid |=> cmd_refuse)
      else $error("command accepted while violation flag set");
   // a loaded byte shows one edge after the request drops
   AST_SPARE_KEEP: assert property (!$past(flash_rd_req, 2)
      |-> $stable(prot_setting[6]))
      else $error("spare flag changed outside load");
   AST_OPEN_ONCE: assert property ($rose(prot_setting[7])
      |-> $past(flash_rd_req, 2))
      else $error("polarity bit set by software");
   AST_HSIZE_LOCK: assert property (!$past(flash_rd_req, 2) &&
      !$past(prot_setting[5]) |-> $stable(prot_setting[4:3]))
      else $error("high size changed while range enabled");
   AST_LSIZE_LOCK: assert property (!$past(flash_rd_req, 2) &&
      !$past(prot_setting[2]) |-> $stable(prot_setting[1:0]))
      else $error("low size changed while range enabled");
   AST_TRANS: assert property (!$past(flash_rd_req, 2)
      |-> ALLOW[{$past(scen), scen}])
      else $error("illegal scenario transition");
endmodule // fsp_monitor

bind fsp_top fsp_monitor u_mon (.ref_clk(ref_clk), .resetn(resetn),
   .cmd_valid(cmd_valid), .cmd_mass(cmd_mass), .cmd_addr(cmd_addr),
   .cmd_accept(cmd_accept), .cmd_refuse(cmd_refuse),
   .protect_violation_flag(protect_violation_flag),
   .prot_setting(prot_setting), .flash_rd_req(flash_rd_req));
`default_nettype wire

// ===== dv/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [63:0] ALLOW = 64'hFF5A_3A18_080C_0A0F;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, flash_rd_valid = 1'b0;
   logic [7:0]  flash_rd_data = 8'h00;
   logic        cmd_valid = 1'b0, cmd_mass = 1'b0;
   logic [15:0] cmd_addr = 16'h0000;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        flash_rd_req, cmd_accept, cmd_refuse;
   logic        protect_violation_flag;
   logic [15:0] flash_rd_addr;
   logic [7:0]  prot_setting;
   logic [1:0]  resp;
   logic [31:0] rd_val;
   int          bad_count = 0;
   int          checks = 0;
   int          cycles = 0;

   fsp_top u_dut (.*);

   initial forever #20 ref_clk = ~ref_clk;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task test_done;
      $display("checks=%0d mismatches=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // write channels are released separately, each on its own handshake
   task wr(input [7:0] a, input [31:0] d, input [3:0] s,
           output logic [1:0] r);
      logic aw, w, a1, w1;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(negedge ref_clk);
         a1 = s_axi_awvalid && s_axi_awready;
         w1 = s_axi_wvalid && s_axi_wready;
         @(posedge ref_clk);
         if (a1) s_axi_awvalid <= 1'b0;
         if (w1) s_axi_wvalid <= 1'b0;
         aw = aw | a1;
         w = w | w1;
      end
      s_axi_bready <= 1'b1;
      do @(negedge ref_clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
   endtask

   task rd(input [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge ref_clk); while (!s_axi_arready);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(negedge ref_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
   endtask

   task boot(input [7:0] v);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      do @(negedge ref_clk); while (!flash_rd_req);
      chk(flash_rd_addr, 16'hFF0D);
      @(posedge ref_clk);
      flash_rd_data <= v;
      flash_rd_valid <= 1'b1;
      @(posedge ref_clk);
      flash_rd_valid <= 1'b0;
      flash_rd_data <= ~v;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(prot_setting, v);
      @(posedge ref_clk);
   endtask

   task setp(input [7:0] v, input [7:0] e);
      wr(8'h00, {24'h00_0000, v}, 4'hF, resp);
      rd(8'h00, rd_val, resp);
      chk(rd_val, {24'h00_0000, e});
   endtask

   // a refusal is cleared again so later commands are judged alone
   task cmd(input [15:0] a, input m, input e);
      cmd_addr <= a;
      cmd_mass <= m;
      cmd_valid <= 1'b1;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      @(negedge ref_clk);
      chk({cmd_refuse, cmd_accept}, {e, !e});
      chk(protect_violation_flag, e);
      @(posedge ref_clk);
      if (e) begin
         wr(8'h04, 32'h0000_0001, 4'hF, resp);
         @(negedge ref_clk);
         chk(protect_violation_flag, 1'b0);
         @(posedge ref_clk);
      end
   endtask

   task t_sizes;
      logic [15:0] hs, le;
      for (int c = 0; c < 4; c++) begin
         hs = 16'hFFFF << (11 + c);
         le = 16'h3FFF + (16'h0400 << c);
         boot(8'hFF);
         if (c == 0) cmd(16'h0000, 1'b1, 1'b0);
         setp(8'(8'h80 | (c << 3) | c), 8'(8'hC0 | (c << 3) | c));
         cmd(hs, 1'b0, 1'b1);
         cmd(hs - 16'h0001, 1'b0, 1'b0);
         cmd(le, 1'b0, 1'b1);
         cmd(le + 16'h0001, 1'b0, 1'b0);
         cmd(16'h3FFF, 1'b0, 1'b0);
      end
   endtask

   task t_lock;
      setp(8'hC0, 8'hDB);
      setp(8'hFF, 8'hDB);
      wr(8'h00, 32'h0000_0024, 4'h0, resp);
      chk(resp, 2'b00);
      @(negedge ref_clk);
      chk(prot_setting, 8'hDB);
      @(posedge ref_clk);
      setp(8'h24, 8'h7F);
      cmd(16'h0000, 1'b0, 1'b1);
      cmd(16'h9000, 1'b1, 1'b1);
      rd(8'h04, rd_val, resp);
      chk(rd_val, 32'h0000_000E);
      wr(8'h08, 32'h0000_0000, 4'hF, resp);
      chk(resp, 2'b10);
      rd(8'h08, rd_val, resp);
      chk(rd_val, 32'h0000_0000);
      chk(resp, 2'b10);
   endtask

   task t_open;
      boot(8'h40);
      cmd(16'hF800, 1'b0, 1'b0);
      cmd(16'hF7FF, 1'b0, 1'b1);
      cmd(16'h43FF, 1'b0, 1'b0);
      cmd(16'h4400, 1'b0, 1'b1);
      cmd(16'h3FFF, 1'b0, 1'b1);
      // a second command while the flag stands is refused
      cmd_addr <= 16'h3FFF;
      cmd_mass <= 1'b0;
      cmd_valid <= 1'b1;
      @(posedge ref_clk);
      cmd_addr <= 16'hF800;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      @(negedge ref_clk);
      chk({cmd_refuse, cmd_accept}, 2'b10);
      chk(protect_violation_flag, 1'b1);
      @(posedge ref_clk);
   endtask

   // every source and target scenario, sizes left at code 00
   task t_trans;
      logic [7:0] es, et;
      for (int s = 0; s < 8; s++) begin
         for (int t = 0; t < 8; t++) begin
            es = {s[2], 1'b1, s[1], 2'b00, s[0], 2'b00};
            et = {t[2], 1'b1, t[1], 2'b00, t[0], 2'b00};
            boot(es);
            setp(et, ALLOW[s * 8 + t] ? et : es);
         end
      end
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         test_done;
      end
   end

   initial begin
      t_sizes;
      t_lock;
      t_open;
      t_trans;
      test_done;
   end
endmodule // testbench
`default_nettype wire
